// ### design/cit_core.sv
// instruction sequencing, cycle timing, on-chip memory moves and debug control
`timescale 1ns/10ps
module cit_core
#(
	parameter int EXT_RAM_AW = 11
)
(
	input wire logic sys_clk,
	input wire logic nrst,
	output logic [15:0] prog_addr,
	input wire logic [7:0] prog_data,
	input wire logic [7:0] acc,
	input wire logic [15:0] dptr,
	input wire logic [7:0] ri_value,
	input wire logic cond_true,
	input wire logic redirect,
	input wire logic [15:0] redirect_pc,
	input wire logic flash_write_sel,
	output logic [EXT_RAM_AW-1:0] ext_ram_addr,
	output logic [15:0] flash_addr,
	output logic [7:0] store_data,
	output logic ext_ram_we,
	output logic ext_ram_re,
	output logic flash_we,
	input wire logic [7:0] ext_ram_rdata,
	output logic [7:0] load_data,
	output logic load_valid,
	output logic instr_done,
	output logic [15:0] instr_pc,
	output logic [7:0] instr_opcode,
	output logic [1:0] instr_len,
	output logic [3:0] instr_cycles,
	output logic instr_taken,
	output logic instr_illegal,
	input wire logic dbg_halt_req,
	input wire logic dbg_run_req,
	input wire logic dbg_step_req,
	input wire logic bkpt_en,
	input wire logic [15:0] bkpt_addr,
	output logic dbg_halted,
	output logic [31:0] dbg_retired
);
	logic rst_n;
	cit_pkg::cit_state_t state;
	logic [3:0] cnt;
	logic [15:0] pc;
	logic [15:0] start_q;
	logic [7:0] opcode_q;
	logic [7:0] rel_q;
	logic [15:0] target_q;
	logic taken_q;
	logic step_q;
	logic halt_pend;
	logic [15:0] mem_addr;
	logic is_rd_q;

	logic running;
	logic first;
	logic [7:0] cur_op;
	logic [15:0] cur_start;
	logic [7:0] cur_rel;
	logic [15:0] next_addr;
	logic [15:0] target;
	logic [15:0] new_pc;
	logic [15:0] code_addr;
	logic last_base;
	logic take_now;
	logic instr_end;
	logic enter_halt;

	logic [1:0] dec_len;
	logic [3:0] dec_cycles;
	logic dec_cond;
	logic dec_rel_jump;
	logic dec_xrd;
	logic dec_xwr;
	logic dec_xdptr;
	logic dec_crd;
	logic dec_cpc;
	logic dec_illegal;

	cit_rst_sync u_rst_sync
	(
		.sys_clk(sys_clk),
		.nrst(nrst),
		.rst_sync_n(rst_n)
	);

	// the opcode byte is decoded straight from the fetch port in the first cycle
	cit_decode u_decode
	(
		.opcode(cur_op),
		.byte_len(dec_len),
		.base_cycles(dec_cycles),
		.cond_branch(dec_cond),
		.rel_jump(dec_rel_jump),
		.xdata_rd(dec_xrd),
		.xdata_wr(dec_xwr),
		.xdata_dptr(dec_xdptr),
		.code_rd(dec_crd),
		.code_pc_rel(dec_cpc),
		.illegal(dec_illegal)
	);

	////////////////////////////////////////////////////////////////////////////////
	// cycle bookkeeping

	assign running = (state == cit_pkg::CIT_RUN);
	assign first = (cnt == 4'h0);
	assign cur_op = first ? prog_data : opcode_q;
	assign cur_start = first ? pc : start_q;
	assign cur_rel = (cnt == {2'h0, dec_len} - 4'h1) ? prog_data : rel_q;
	assign next_addr = cur_start + {14'h0000, dec_len};
	assign target = next_addr + {{8{cur_rel[7]}}, cur_rel};
	assign code_addr = (dec_cpc ? next_addr : dptr) + {8'h00, acc};

	// one count per clock, no machine cycle grouping
	assign last_base = (cnt == dec_cycles - 4'h1);

	// the taken decision lands on the last base cycle and buys one more
	assign take_now = running && last_base && !taken_q && (dec_rel_jump || (dec_cond && cond_true));
	assign instr_end = running && ((last_base && !take_now && !taken_q)
		|| (taken_q && cnt == dec_cycles + cit_pkg::CIT_TAKEN_EXTRA - 4'h1));

	// an interrupt vector arrives as a redirect, so stepping follows it into the handler
	assign new_pc = redirect ? redirect_pc : (taken_q ? target_q : next_addr);

	assign enter_halt = instr_end && (halt_pend || dbg_halt_req || step_q
		|| (bkpt_en && new_pc == bkpt_addr));

	assign prog_addr = pc;
	assign dbg_halted = !running;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt <= 4'h0;
		else if (!running || instr_end)
			cnt <= 4'h0;
		else if (cnt < cit_pkg::CIT_MAX_CYCLES)
			cnt <= cnt + 4'h1;
	end

	// a one-cycle instruction ends in its fetch cycle, so back to back is one per clock
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			pc <= cit_pkg::CIT_RESET_PC;
		else if (instr_end)
			pc <= new_pc;
		else if (running && first && dec_crd)
			pc <= code_addr;
		else if (running && cnt + 4'h1 < {2'h0, dec_len})
			pc <= pc + 16'h0001;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			opcode_q <= 8'h00;
			start_q <= 16'h0000;
		end
		else if (running && first)
		begin
			opcode_q <= prog_data;
			start_q <= pc;
		end
	end

	// the relative offset is always the last byte of a branch
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			rel_q <= 8'h00;
		else if (running && cnt == {2'h0, dec_len} - 4'h1)
			rel_q <= prog_data;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			taken_q <= 1'b0;
			target_q <= 16'h0000;
		end
		else if (take_now)
		begin
			taken_q <= 1'b1;
			target_q <= target;
		end
		else if (instr_end)
			taken_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// on-chip data and flash moves

	// the ram address is cut to the on-chip ram size, the flash address keeps all 16 bits; there is no off-chip port at all
	assign ext_ram_addr = mem_addr[EXT_RAM_AW-1:0];
	assign flash_addr = mem_addr;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mem_addr <= 16'h0000;
			store_data <= 8'h00;
		end
		else if (running && first && (dec_xrd || dec_xwr))
		begin
			mem_addr <= dec_xdptr ? dptr : {cit_pkg::CIT_XDATA_PAGE, ri_value};
			store_data <= acc;
		end
	end

	// strobes stand for the single cycle at count one of the move
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ext_ram_we <= 1'b0;
			ext_ram_re <= 1'b0;
			flash_we <= 1'b0;
		end
		else
		begin
			ext_ram_we <= running && first && dec_xwr && !flash_write_sel;
			flash_we <= running && first && dec_xwr && flash_write_sel;
			ext_ram_re <= running && first && dec_xrd;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			is_rd_q <= 1'b0;
		else if (running && first)
			is_rd_q <= dec_xrd;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			load_data <= 8'h00;
			load_valid <= 1'b0;
		end
		else if (running && dec_crd && cnt == cit_pkg::CIT_CODE_MOVE_LOAD_CNT)
		begin
			load_data <= prog_data;
			load_valid <= 1'b1;
		end
		else if (running && is_rd_q && !first && cnt == cit_pkg::CIT_EXT_MOVE_LOAD_CNT)
		begin
			load_data <= ext_ram_rdata;
			load_valid <= 1'b1;
		end
		else
			load_valid <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// retirement report

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			instr_done <= 1'b0;
		else
			instr_done <= instr_end;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			instr_pc <= 16'h0000;
			instr_opcode <= 8'h00;
			instr_len <= 2'h0;
			instr_cycles <= 4'h0;
			instr_taken <= 1'b0;
			instr_illegal <= 1'b0;
		end
		else if (instr_end)
		begin
			instr_pc <= cur_start;
			instr_opcode <= cur_op;
			instr_len <= dec_len;
			instr_cycles <= cnt + 4'h1;
			instr_taken <= taken_q;
			instr_illegal <= dec_illegal;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// debug control on dedicated flops only, nothing of the application is borrowed

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			state <= cit_pkg::CIT_RUN;
		else
		begin
			unique case (state)
				cit_pkg::CIT_RUN:
				begin
					if (enter_halt)
						state <= cit_pkg::CIT_HALT;
				end
				cit_pkg::CIT_HALT:
				begin
					if (dbg_run_req || dbg_step_req)
						state <= cit_pkg::CIT_RUN;
				end
			endcase
		end
	end

	// a halt request mid-instruction waits for the boundary; at the boundary the clear wins and the request halts directly
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			halt_pend <= 1'b0;
		else if (running && dbg_halt_req && !instr_end)
			halt_pend <= 1'b1;
		else if (enter_halt)
			halt_pend <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			step_q <= 1'b0;
		else if (!running && dbg_step_req)
			step_q <= 1'b1;
		else if (!running && dbg_run_req)
			step_q <= 1'b0;
		else if (instr_end)
			step_q <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			dbg_retired <= 32'h00000000;
		else if (instr_end)
			dbg_retired <= dbg_retired + 32'h00000001;
	end
endmodule

// ### design/cit_decode.sv
// opcode to length, base cycle count and access class
`timescale 1ns/10ps
module cit_decode
(
	input wire logic [7:0] opcode,
	output logic [1:0] byte_len,
	output logic [3:0] base_cycles,
	output logic cond_branch,
	output logic rel_jump,
	output logic xdata_rd,
	output logic xdata_wr,
	output logic xdata_dptr,
	output logic code_rd,
	output logic code_pc_rel,
	output logic illegal
);
	logic [3:0] hi;
	logic [3:0] lo;
	logic indirect;

	// rows follow the standard 8051 opcode map
	always_comb
	begin
		hi = opcode[7:4];
		lo = opcode[3:0];
		byte_len = 2'h1;
		cond_branch = 1'b0;
		rel_jump = 1'b0;
		indirect = 1'b0;
		illegal = 1'b0;
		xdata_rd = (hi == 4'hE) && (lo == 4'h0 || lo == 4'h2 || lo == 4'h3);
		xdata_wr = (hi == 4'hF) && (lo == 4'h0 || lo == 4'h2 || lo == 4'h3);
		xdata_dptr = (lo == 4'h0);
		code_rd = (opcode == cit_pkg::CIT_OP_CODE_MOVE_PC) || (opcode == cit_pkg::CIT_OP_CODE_MOVE_DPTR);
		code_pc_rel = (opcode == cit_pkg::CIT_OP_CODE_MOVE_PC);
		if (lo >= 4'h8)
		begin
			// working register forms: one byte unless an operand follows
			if (hi == 4'h7 || hi == 4'h8 || hi == 4'hA || hi == 4'hD)
				byte_len = 2'h2;
			if (hi == 4'hB)
				byte_len = 2'h3;
			cond_branch = (hi == 4'hB) || (hi == 4'hD);
		end
		else if (lo >= 4'h6)
		begin
			// indirect forms cost one extra cycle except in the 7x, 8x and Ax rows
			indirect = !(hi == 4'h7 || hi == 4'h8 || hi == 4'hA);
			if (hi == 4'h7 || hi == 4'h8 || hi == 4'hA)
				byte_len = 2'h2;
			if (hi == 4'hB)
				byte_len = 2'h3;
			cond_branch = (hi == 4'hB);
		end
		else
		begin
			case (lo)
				4'h0:
				begin
					if (hi == 4'h1 || hi == 4'h2 || hi == 4'h3 || hi == 4'h9)
						byte_len = 2'h3;
					else if (hi != 4'h0 && hi != 4'hE && hi != 4'hF)
						byte_len = 2'h2;
					cond_branch = (hi >= 4'h1) && (hi <= 4'h7);
					rel_jump = (opcode == cit_pkg::CIT_OP_SJMP);
				end
				4'h1: byte_len = 2'h2;
				4'h2:
				begin
					if (hi <= 4'h1)
						byte_len = 2'h3;
					else if (hi >= 4'h4 && hi <= 4'hD)
						byte_len = 2'h2;
				end
				4'h3:
				begin
					if (hi >= 4'h4 && hi <= 4'h6)
						byte_len = 2'h3;
				end
				4'h4:
				begin
					// immediate arithmetic forms are two bytes
					if ((hi >= 4'h2 && hi <= 4'h7) || hi == 4'h9)
						byte_len = 2'h2;
					if (hi == 4'hB)
						byte_len = 2'h3;
					cond_branch = (hi == 4'hB);
				end
				default:
				begin
					// direct forms are two bytes
					byte_len = 2'h2;
					if (hi == 4'h7 || hi == 4'h8 || hi == 4'hB || hi == 4'hD)
						byte_len = 2'h3;
					cond_branch = (hi == 4'hB) || (hi == 4'hD);
					illegal = (opcode == cit_pkg::CIT_OP_RESERVED);
					if (illegal)
						byte_len = 2'h1;
				end
			endcase
		end
		// cycles equal bytes except for the few slow classes
		base_cycles = {2'h0, byte_len};
		if (indirect)
			base_cycles = {2'h0, byte_len} + cit_pkg::CIT_INDIRECT_EXTRA;
		if (xdata_rd || xdata_wr)
			base_cycles = cit_pkg::CIT_EXT_MOVE_CYCLES;
		if (code_rd)
			base_cycles = cit_pkg::CIT_CODE_MOVE_CYCLES;
		if (opcode == cit_pkg::CIT_OP_MUL)
			base_cycles = cit_pkg::CIT_MUL_CYCLES;
		if (opcode == cit_pkg::CIT_OP_DIV)
			base_cycles = cit_pkg::CIT_DIV_CYCLES;
	end
endmodule

// ### design/cit_pkg.sv
// shared constants, opcodes and state type of the instruction timing core
// Operation
// - Every instruction is timed in single system clock cycles, never in grouped machine cycles.
// - Most instructions take as many clock cycles as they have program bytes.
// - A conditional branch that is not taken ends one cycle sooner than one that is taken.
// - No instruction takes more than eight cycles, and divide takes exactly eight.
// - The decoder covers the full set of 109 distinct instructions.
// - Opcode encodings and addressing modes follow the classic 8051 set; only timing differs.
// - The external data write reaches either the on-chip data RAM or the on-chip program flash.
// - Software can read and write program flash one byte at a time with the code-byte and external moves.
// - No access ever leaves the chip; every address lands in on-chip storage.
// - Add, add-with-carry and subtract-with-borrow from a working register are one byte and one cycle.
// - The same three operations from a direct byte are two bytes and two cycles.
// - The same three operations from indirect RAM are one byte but two cycles.
// - The same three operations with an immediate operand are two bytes and two cycles.
// - Debug offers breakpoints plus start, stop and single step, also inside interrupt handlers.
// - Debug uses none of the RAM, stack, timers or other resources the application owns.
// - The core runs from up to 25 MHz and can retire one instruction per clock.
package cit_pkg;
	localparam logic [15:0] CIT_RESET_PC = 16'h0000;
	localparam logic [3:0] CIT_MAX_CYCLES = 4'h8;
	localparam logic [3:0] CIT_MUL_CYCLES = 4'h4;
	localparam logic [3:0] CIT_DIV_CYCLES = 4'h8;
	localparam logic [3:0] CIT_EXT_MOVE_CYCLES = 4'h3;
	localparam logic [3:0] CIT_CODE_MOVE_CYCLES = 4'h3;
	localparam logic [3:0] CIT_INDIRECT_EXTRA = 4'h1;
	localparam logic [3:0] CIT_TAKEN_EXTRA = 4'h1;
	localparam logic [3:0] CIT_EXT_MOVE_STROBE_CNT = 4'h1;
	localparam logic [3:0] CIT_EXT_MOVE_LOAD_CNT = 4'h2;
	localparam logic [3:0] CIT_CODE_MOVE_LOAD_CNT = 4'h1;
	localparam logic [7:0] CIT_OP_DIV = 8'h84;
	localparam logic [7:0] CIT_OP_MUL = 8'hA4;
	localparam logic [7:0] CIT_OP_SJMP = 8'h80;
	localparam logic [7:0] CIT_OP_CODE_MOVE_PC = 8'h83;
	localparam logic [7:0] CIT_OP_CODE_MOVE_DPTR = 8'h93;
	localparam logic [7:0] CIT_OP_RESERVED = 8'hA5;
	localparam logic [7:0] CIT_XDATA_PAGE = 8'h00;
	typedef enum logic {CIT_RUN, CIT_HALT} cit_state_t;
endpackage

// ### design/cit_rst_sync.sv
// reset release synchroniser
`timescale 1ns/10ps
module cit_rst_sync
(
	input wire logic sys_clk,
	input wire logic nrst,
	output logic rst_sync_n
);
	logic meta_n;

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			meta_n <= 1'b1;
			rst_sync_n <= meta_n;
		end
	end
endmodule

// ### sim/cit_core_asserts.sv
// timing checker bound to the instruction timing core
`timescale 1ns/10ps
module cit_core_asserts
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [15:0] prog_addr,
	input wire logic instr_done,
	input wire logic [7:0] instr_opcode,
	input wire logic [1:0] instr_len,
	input wire logic [3:0] instr_cycles,
	input wire logic instr_taken,
	input wire logic ext_ram_we,
	input wire logic ext_ram_re,
	input wire logic flash_we,
	input wire logic load_valid,
	input wire logic dbg_halted
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	logic fam;
	logic [3:0] lo;
	// add, add-with-carry and subtract-with-borrow rows share the low nibble layout
	assign fam = instr_done && (instr_opcode[7:4] == 4'h2 || instr_opcode[7:4] == 4'h3 || instr_opcode[7:4] == 4'h9);
	assign lo = instr_opcode[3:0];
	AST_MAX: assert property (instr_done |-> instr_cycles <= 4'h8 && instr_cycles != 4'h0)
		else $error("cycle count out of range");
	AST_DIV: assert property (instr_done && instr_opcode == 8'h84 |-> instr_cycles == 4'h8)
		else $error("divide not eight cycles");
	AST_REG: assert property (fam && lo[3] |-> instr_len == 2'h1 && instr_cycles == 4'h1)
		else $error("register form timing wrong");
	AST_DIR: assert property (fam && lo == 4'h5 |-> instr_len == 2'h2 && instr_cycles == 4'h2)
		else $error("direct form timing wrong");
	AST_IND: assert property (fam && lo[3:1] == 3'h3 |-> instr_len == 2'h1 && instr_cycles == 4'h2)
		else $error("indirect form timing wrong");
	AST_IMM: assert property (fam && lo == 4'h4 |-> instr_len == 2'h2 && instr_cycles == 4'h2)
		else $error("immediate form timing wrong");
	AST_BRANCH: assert property (instr_done && instr_opcode == 8'h60 |-> instr_cycles == (instr_taken ? 4'h3 : 4'h2))
		else $error("branch timing wrong");
	AST_XWR: assert property (ext_ram_we |-> !flash_we ##2 instr_done)
		else $error("external write misplaced");
	AST_XRD: assert property (ext_ram_re |-> ##2 (load_valid && instr_done))
		else $error("external read load late");
	AST_HOLD: assert property (dbg_halted && $past(dbg_halted) |-> $stable(prog_addr) && !instr_done)
		else $error("core moved while halted");
endmodule
bind cit_core cit_core_asserts u_chk (.*);

// ### sim/cit_core_tb.sv
// self-checking bench for the instruction timing core
`timescale 1ns/10ps
module cit_core_tb;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] acc = 8'h00;
	logic [15:0] dptr = 16'h00F0;
	logic [7:0] ri_value = 8'h00;
	logic redirect = 1'b0;
	logic [15:0] redirect_pc = 16'h0000;
	logic cond_true = 1'b0;
	logic flash_write_sel = 1'b0;
	logic dbg_halt_req = 1'b0;
	logic dbg_run_req = 1'b0;
	logic dbg_step_req = 1'b0;
	logic bkpt_en = 1'b0;
	logic [15:0] bkpt_addr = 16'h0000;
	logic [15:0] prog_addr, flash_addr, instr_pc;
	logic [7:0] prog_data, store_data, ext_ram_rdata, load_data, instr_opcode;
	logic [10:0] ext_ram_addr;
	logic ext_ram_we, ext_ram_re, flash_we, load_valid, instr_done, instr_taken, instr_illegal, dbg_halted;
	logic [1:0] instr_len;
	logic [3:0] instr_cycles;
	logic [31:0] dbg_retired;
	logic linked = 1'b0;
	logic [15:0] epc = 16'h0000;
	int errors = 0;
	int cmp_count = 0;
	logic [7:0] prog [31] = '{8'h28, 8'h25, 8'h10, 8'h26, 8'h24, 8'h33, 8'h38, 8'h35, 8'h10, 8'h37, 8'h34,
		8'h01, 8'h98, 8'h95, 8'h10, 8'h96, 8'h94, 8'h05, 8'hA4, 8'h84, 8'h60, 8'h02, 8'h00, 8'h00,
		8'h60, 8'h05, 8'hF0, 8'hE0, 8'h93, 8'hF0, 8'hA5};
	cit_core u_dut (.*);
	cit_mem_model u_mem (.*);
	always #4 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected %s: expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task automatic finish_test;
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// waits for the next retire; the gap to the previous one must be the cycle count
	task automatic exec(input logic [7:0] op, input logic [1:0] len, input logic [3:0] cyc, input logic tk);
		int n;
		n = 0;
		do
		begin
			@(negedge sys_clk);
			n++;
		end
		while (instr_done !== 1'b1 && n < 20);
		check("opcode", instr_opcode, op);
		check("length", instr_len, len);
		check("cycles", instr_cycles, cyc);
		check("taken", instr_taken, tk);
		check("pc", instr_pc, epc);
		if (linked)
			check("gap", n, cyc);
		linked = 1'b1;
		epc = epc + 16'(len);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_arith;
		exec(8'h28, 2'h1, 4'h1, 1'b0);
		exec(8'h25, 2'h2, 4'h2, 1'b0);
		exec(8'h26, 2'h1, 4'h2, 1'b0);
		exec(8'h24, 2'h2, 4'h2, 1'b0);
		exec(8'h38, 2'h1, 4'h1, 1'b0);
		exec(8'h35, 2'h2, 4'h2, 1'b0);
		exec(8'h37, 2'h1, 4'h2, 1'b0);
		exec(8'h34, 2'h2, 4'h2, 1'b0);
		exec(8'h98, 2'h1, 4'h1, 1'b0);
		exec(8'h95, 2'h2, 4'h2, 1'b0);
		exec(8'h96, 2'h1, 4'h2, 1'b0);
		exec(8'h94, 2'h2, 4'h2, 1'b0);
		exec(8'hA4, 2'h1, 4'h4, 1'b0);
		exec(8'h84, 2'h1, 4'h8, 1'b0);
	endtask
	task automatic t_branch;
		cond_true = 1'b1;
		exec(8'h60, 2'h2, 4'h3, 1'b1);
		check("target", prog_addr, 16'h0018);
		epc = 16'h0018;
		cond_true = 1'b0;
		exec(8'h60, 2'h2, 4'h2, 1'b0);
	endtask
	task automatic t_ext;
		flash_write_sel = 1'b1;
		exec(8'hF0, 2'h1, 4'h3, 1'b0);
		flash_write_sel = 1'b0;
		check("flash", u_mem.rom[8'hF0], 8'h00);
		exec(8'hE0, 2'h1, 4'h3, 1'b0);
		check("xread", load_data, 8'hFF);
		exec(8'h93, 2'h1, 4'h3, 1'b0);
		check("code_read", load_data, 8'h00);
		exec(8'hF0, 2'h1, 4'h3, 1'b0);
		check("ram", u_mem.ram[11'h0F0], 8'h00);
		exec(8'hA5, 2'h1, 4'h1, 1'b0);
		check("illegal", instr_illegal, 1'b1);
	endtask
	task automatic t_debug;
		logic [15:0] a;
		logic [31:0] r;
		dbg_halt_req = 1'b1;
		@(negedge sys_clk);
		dbg_halt_req = 1'b0;
		repeat (3) @(negedge sys_clk);
		a = prog_addr;
		r = dbg_retired;
		repeat (3) @(negedge sys_clk);
		check("halted", dbg_halted, 1'b1);
		check("held_pc", prog_addr, a);
		dbg_step_req = 1'b1;
		@(negedge sys_clk);
		dbg_step_req = 1'b0;
		repeat (4) @(negedge sys_clk);
		check("step", dbg_retired, r + 1);
		check("step_halt", dbg_halted, 1'b1);
		bkpt_en = 1'b1;
		bkpt_addr = prog_addr + 16'h0003;
		dbg_run_req = 1'b1;
		@(negedge sys_clk);
		dbg_run_req = 1'b0;
		repeat (8) @(negedge sys_clk);
		check("bkpt_pc", prog_addr, bkpt_addr);
		check("bkpt_count", dbg_retired, r + 4);
		// a vector redirect on the stepped instruction is followed, as into a handler
		redirect = 1'b1;
		redirect_pc = 16'h0030;
		dbg_step_req = 1'b1;
		@(negedge sys_clk);
		dbg_step_req = 1'b0;
		repeat (4) @(negedge sys_clk);
		check("redirect_pc", prog_addr, 16'h0030);
		check("redirect_halt", dbg_halted, 1'b1);
		redirect = 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		for (int i = 0; i < 256; i++)
			u_mem.rom[i] = (i < 31) ? prog[i] : 8'h00;
		u_mem.rom[8'hF0] = 8'hFF;
		u_mem.ram[11'h0F0] = 8'hFF;
		repeat (4) @(negedge sys_clk);
		nrst = 1'b1;
		t_arith;
		t_branch;
		t_ext;
		t_debug;
		finish_test;
	end
	// the whole run needs about 85 cycles
	initial
	begin
		#8000;
		errors++;
		finish_test;
	end
endmodule

// ### sim/cit_mem_model.sv
// program flash and data ram model facing the core
`timescale 1ns/10ps
module cit_mem_model
(
	input wire logic sys_clk,
	input wire logic [15:0] prog_addr,
	output logic [7:0] prog_data,
	input wire logic [10:0] ext_ram_addr,
	input wire logic [15:0] flash_addr,
	input wire logic [7:0] store_data,
	input wire logic ext_ram_we,
	input wire logic ext_ram_re,
	input wire logic flash_we,
	output logic [7:0] ext_ram_rdata
);
	logic [7:0] rom [256];
	logic [7:0] ram [2048];
	initial ext_ram_rdata = 8'h00;
	// only the low page exists; above it a changing pattern shows up stray fetches
	assign prog_data = (prog_addr[15:8] == 8'h00) ? rom[prog_addr[7:0]] : ~prog_addr[7:0];
	always @(posedge sys_clk)
	begin
		if (flash_we)
			rom[flash_addr[7:0]] <= store_data;
		if (ext_ram_we)
			ram[ext_ram_addr] <= store_data;
	end
	// read data holds one cycle only, then toggles so a late sample is caught
	always @(posedge sys_clk)
	begin
		if (ext_ram_re)
			ext_ram_rdata <= ram[ext_ram_addr];
		else
			ext_ram_rdata <= ~ext_ram_rdata;
	end
endmodule
